/* shared/cdts_pkg.sv */
// Package of constants and carrier types for the capture core
package cdts_pkg;
    localparam int          FRAME_W      = 32;      // Packed frame width
    localparam int          SEQ_STATES_W = 2;       // Sequence state bits
    localparam int          TRIG_W       = 2;       // Trigger word index bits
    localparam int          DELAY_W      = 16;      // Trigger delay counter
    localparam logic [15:0] DELAY_MAX    = 16'hC350; // Fifty thousand samples
    localparam int          FIFO_DEPTH   = 8;       // Frame buffer depth
    localparam int          ACQ_AW       = 10;      // Acquisition RAM address
    localparam int          TRIG_AW      = 12;      // Lookup RAM address bits
    localparam real         WORD_RATE_MHZ = 12.5;   // Highest frame rate
    localparam real         CLK_MHZ       = 100.0;  // Core clock rate
    // Least cycles between frames derived from the two rates
    localparam int WORD_GAP = int'(CLK_MHZ / WORD_RATE_MHZ);
    localparam logic [3:0]  SPF_W4  = 4'h8;         // Samples per frame
    localparam logic [3:0]  SPF_W8  = 4'h4;
    localparam logic [3:0]  SPF_W16 = 4'h2;
    localparam logic [3:0]  SPF_W32 = 4'h1;
    localparam logic [2:0]  TW_NARROW = 3'h4;       // Trigger words 4/8/32
    localparam logic [2:0]  TW_W16    = 3'h2;       // Trigger words 16-bit

    // Sample width selection
    typedef enum logic [1:0] {CDTS_W4, CDTS_W8, CDTS_W16, CDTS_W32} cdts_width_t;

    // Frame travelling down the capture path
    typedef struct packed {
        logic [FRAME_W-1:0] data;  // Packed samples
        logic               qual;  // Qualified for storage
    } cdts_frame_t;

    // Processor load port for the lookup RAMs
    typedef struct packed {
        logic                sel_seq; // Target sequence RAM
        logic [TRIG_AW-1:0]  addr;    // Entry address
        logic [3:0]          data;    // Entry value
        logic                we;      // Write strobe
    } cdts_load_t;
endpackage : cdts_pkg

/* core/cdts_fifo.sv */
// Frame buffer FIFO with valid/ready on both sides
`timescale 1ns/10ps
module cdts_fifo #(
    parameter int WIDTH = 33,
    parameter int DEPTH = 8
) (
    input  wire logic             mclk,
    input  wire logic             sys_rst,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic      [WIDTH-1:0] out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];   // Storage words
    logic [AW-1:0]    wr_reg;        // Write pointer
    logic [AW-1:0]    rd_reg;        // Read pointer
    logic [AW:0]      cnt_reg;       // Fill level
    logic             push;          // Accepted write
    logic             pop;           // Accepted read

    assign push     = in_valid && in_ready;
    assign pop      = out_valid && out_ready;
    assign in_ready = (cnt_reg != (AW+1)'(DEPTH));           // Honest full
    assign out_valid = (cnt_reg != '0);                      // Honest empty
    assign out_data = mem[rd_reg];

    // Storage write
    always_ff @(posedge mclk)
    begin
        if (push)
            mem[wr_reg] <= in_data;
    end

    // Pointers and fill level
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            wr_reg  <= '0;
            rd_reg  <= '0;
            cnt_reg <= '0;
        end
        else
        begin
            if (push)
                wr_reg <= (wr_reg == AW'(DEPTH-1)) ? '0 : wr_reg + 1'b1;
            if (pop)
                rd_reg <= (rd_reg == AW'(DEPTH-1)) ? '0 : rd_reg + 1'b1;
            cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : cdts_fifo

/* core/cdts_core.sv */
// Capture core: demultiplexer, trigger lookup, sequencer and store
`timescale 1ns/10ps
module cdts_core
    import cdts_pkg::*;
#(
    parameter int           ACQ_DEPTH = 1 << ACQ_AW,
    parameter logic [15:0]  STOP_DELAY_MAX = DELAY_MAX
) (
    input  wire logic               mclk,
    input  wire logic               sys_rst,
    input  wire logic [FRAME_W-1:0] pod_data,
    input  wire logic               pod_qual,
    input  wire logic               pod_strobe,
    input  wire cdts_width_t        width_sel,
    input  wire logic               qual_enable,
    input  wire logic [DELAY_W-1:0] stop_delay,
    input  wire cdts_load_t         load_port,
    input  wire logic               arm_start,
    input  wire logic               manual_stop,
    input  wire logic [ACQ_AW-1:0]  read_addr,
    output logic [FRAME_W-1:0]      read_data,
    output logic                    running,
    output logic                    stopped,
    output logic [ACQ_AW-1:0]       write_addr,
    output logic                    frame_lost
);
    // Pod pins: two-flop synchronisers
    logic [FRAME_W-1:0] pd_s1_reg, pd_s2_reg;   // Data sync stages
    logic [1:0]         pq_s1_reg, pq_s2_reg;   // Qualifier, strobe stages
    logic               strobe_d_reg;           // Strobe edge history
    logic               samp;                   // New sample event

    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            pd_s1_reg    <= '0;
            pd_s2_reg    <= '0;
            pq_s1_reg    <= '0;
            pq_s2_reg    <= '0;
            strobe_d_reg <= 1'b0;
        end
        else
        begin
            pd_s1_reg    <= pod_data;
            pd_s2_reg    <= pd_s1_reg;
            pq_s1_reg    <= {pod_qual, pod_strobe};
            pq_s2_reg    <= pq_s1_reg;
            strobe_d_reg <= pq_s2_reg[0];
        end
    end
    // Edge taken only after the second stage
    assign samp = pq_s2_reg[0] && !strobe_d_reg;

    // Run control
    typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_DELAY, ST_STOP} cdts_run_t;
    cdts_run_t run_reg;

    // Demultiplexer: shift samples into a frame
    logic [FRAME_W-1:0] shift_reg;     // Frame assembly
    logic [3:0]         cnt_reg;       // Samples held
    logic [3:0]         spf;           // Samples per frame
    logic               frame_done;    // Frame complete
    logic [FRAME_W-1:0] frame_data;    // Assembled frame

    always_comb
    begin
        case (width_sel)
            CDTS_W4:  spf = SPF_W4;
            CDTS_W8:  spf = SPF_W8;
            CDTS_W16: spf = SPF_W16;
            default:  spf = SPF_W32;
        endcase
    end

    always_comb
    begin
        case (width_sel)
            CDTS_W4:  frame_data = {pd_s2_reg[3:0], shift_reg[31:4]};
            CDTS_W8:  frame_data = {pd_s2_reg[7:0], shift_reg[31:8]};
            CDTS_W16: frame_data = {pd_s2_reg[15:0], shift_reg[31:16]};
            default:  frame_data = pd_s2_reg;
        endcase
    end
    assign frame_done = samp && (cnt_reg == spf - 4'h1);

    // Sample shifter; only while acquiring, so frames restart on arm
    always_ff @(posedge mclk)
    begin
        if (sys_rst || run_reg == ST_IDLE || run_reg == ST_STOP)
        begin
            shift_reg <= '0;
            cnt_reg   <= '0;
        end
        else if (samp)
        begin
            shift_reg <= frame_data;
            cnt_reg   <= frame_done ? 4'h0 : cnt_reg + 4'h1;
        end
    end

    // Frame register feeding buffer and trigger lookup
    cdts_frame_t fr_reg;           // Latest frame
    logic        fr_vld_reg;       // Frame pending
    logic        fifo_ready;       // Buffer has room
    cdts_frame_t fifo_out;         // Buffered frame
    logic        fifo_valid;       // Buffered frame present
    logic        acq_ready;        // Store may take a word

    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            fr_reg     <= '0;
            fr_vld_reg <= 1'b0;
        end
        else
        begin
            fr_vld_reg <= frame_done && run_reg != ST_IDLE
                          && run_reg != ST_STOP;
            if (frame_done)
            begin
                fr_reg.data <= frame_data;
                // Qualifier counts only in 32-bit mode
                fr_reg.qual <= !(qual_enable && width_sel == CDTS_W32)
                               || pq_s2_reg[1];
            end
        end
    end

    // Lost frame flag: buffer full when a frame arrives (sticky, set wins)
    always_ff @(posedge mclk)
    begin
        if (sys_rst || arm_start)
            frame_lost <= 1'b0;
        if (!sys_rst && fr_vld_reg && !fifo_ready)
            frame_lost <= 1'b1;
    end

    cdts_fifo #(
        .WIDTH ($bits(cdts_frame_t)),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .mclk      (mclk),
        .sys_rst   (sys_rst),
        .in_data   (fr_reg),
        .in_valid  (fr_vld_reg),
        .in_ready  (fifo_ready),
        .out_data  (fifo_out),
        .out_valid (fifo_valid),
        .out_ready (acq_ready)
    );

    // Acquisition RAM; after a stop the store still drains frames already
    // in flight, so the last delayed sample lands if it ends a frame, and none is left stale
    // for the next run. The host waits a few cycles past stopped to read.
    logic [FRAME_W-1:0] acq_mem [ACQ_DEPTH];
    assign acq_ready = (run_reg != ST_IDLE);

    always_ff @(posedge mclk)
    begin
        if (fifo_valid && acq_ready && fifo_out.qual)
            acq_mem[write_addr] <= fifo_out.data;
        read_data <= acq_mem[read_addr];
    end

    always_ff @(posedge mclk)
    begin
        if (sys_rst || arm_start)
            write_addr <= '0;
        else if (fifo_valid && acq_ready && fifo_out.qual)
            write_addr <= write_addr + 1'b1;               // Circular store
    end

    // Trigger lookup and sequencer RAMs, loaded by processor
    logic [1:0] trig_mem [1 << TRIG_AW];  // Action per frame value
    logic [3:0] seq_mem  [1 << (SEQ_STATES_W + TRIG_W + 1)]; // Next, hit
    logic [1:0] trig_act_reg;             // Lookup result
    logic       trig_vld_reg;             // Lookup result valid
    logic [SEQ_STATES_W-1:0] seq_reg;     // Sequence state
    logic [3:0] seq_word;                 // Sequencer RAM output
    logic       hit;                      // Sequence complete

    always_ff @(posedge mclk)
    begin
        if (load_port.we && !load_port.sel_seq)
            trig_mem[load_port.addr] <= load_port.data[1:0];
        if (load_port.we && load_port.sel_seq)
            seq_mem[load_port.addr[4:0]] <= load_port.data;
        // Low frame bits address the lookup; folding keeps it small
        trig_act_reg <= trig_mem[fr_reg.data[TRIG_AW-1:0]
                        ^ fr_reg.data[FRAME_W-1:FRAME_W-TRIG_AW]];
    end

    always_ff @(posedge mclk)
    begin
        if (sys_rst)
            trig_vld_reg <= 1'b0;
        else
            trig_vld_reg <= fr_vld_reg;
    end

    // Sequencer word holds next state and a hit bit; 16-bit mode
    // selects the upper half of the sequencer RAM
    assign seq_word = seq_mem[{width_sel == CDTS_W16, seq_reg,
                               trig_act_reg}];
    assign hit = seq_word[3];

    always_ff @(posedge mclk)
    begin
        if (sys_rst || arm_start)
            seq_reg <= '0;
        else if (trig_vld_reg && run_reg == ST_RUN)
            seq_reg <= seq_word[SEQ_STATES_W-1:0];
    end

    // Run state machine with post-trigger delay
    logic [DELAY_W-1:0] dly_reg;   // Remaining delay samples
    logic [DELAY_W-1:0] dly_lim;   // Clamped delay setting
    assign dly_lim = (stop_delay > STOP_DELAY_MAX) ? STOP_DELAY_MAX
                                                   : stop_delay;

    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            run_reg <= ST_IDLE;
            dly_reg <= '0;
        end
        else
        begin
            case (run_reg)
                ST_IDLE, ST_STOP:
                    if (arm_start)
                        run_reg <= ST_RUN;
                ST_RUN:
                    if (manual_stop)
                        run_reg <= ST_STOP;
                    else if (trig_vld_reg && hit)
                    begin
                        dly_reg <= dly_lim;
                        run_reg <= (dly_lim == '0) ? ST_STOP : ST_DELAY;
                    end
                ST_DELAY:
                    if (manual_stop || (samp && dly_reg == 16'h0001))
                        run_reg <= ST_STOP;
                    else if (samp)
                        dly_reg <= dly_reg - 16'h0001;
                default:
                    run_reg <= ST_IDLE;
            endcase
        end
    end

    // Status outputs from flip-flops
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            running <= 1'b0;
            stopped <= 1'b0;
        end
        else
        begin
            running <= run_reg == ST_RUN || run_reg == ST_DELAY;
            stopped <= run_reg == ST_STOP;
        end
    end
endmodule : cdts_core

/* verif/cdts_checker.sv */
// Port checker for the capture core
`timescale 1ns/10ps
module cdts_checker
    import cdts_pkg::*;
(
    input wire logic              mclk,
    input wire logic              sys_rst,
    input wire logic              arm_start,
    input wire logic              manual_stop,
    input wire logic              running,
    input wire logic              stopped,
    input wire logic [ACQ_AW-1:0] write_addr
);
    logic [ACQ_AW-1:0] prev_wa_reg; // Store slot one cycle back
    logic              step;        // Slot advanced by one

    // Slot history for the step and spacing checks
    always_ff @(posedge mclk)
    begin
        prev_wa_reg <= write_addr;
    end
    assign step = (write_addr == prev_wa_reg + 1'b1);

    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    chk_flags_excl :
        assert property (!(running && stopped))
        else $error("run and stop flags together");
    chk_arm_clean :
        assert property (arm_start && !manual_stop |=>
            write_addr == '0 ##1 running)
        else $error("arm did not open a clean run");
    chk_manual_halt :
        assert property (manual_stop && running |->
            ##[1:3] (!running && stopped))
        else $error("manual stop not obeyed");
    chk_stop_hold :
        assert property (stopped && !arm_start && !$past(arm_start) |=>
            stopped)
        else $error("stop flag dropped without arm");
    chk_slot_step :
        assert property ($changed(write_addr) |-> step || write_addr == '0)
        else $error("store slot jumped");
    chk_word_gap :
        assert property (step |=> !step [*7])
        else $error("frames stored faster than word rate");
    chk_stop_frozen :
        assert property (stopped [*4] ##0 !arm_start |=> $stable(write_addr))
        else $error("store after stop");
    chk_idle_empty :
        assert property (!running && !stopped |-> write_addr == '0)
        else $error("store while idle");

    // Main scenarios reached
    cover property (manual_stop && running);
    cover property ($rose(stopped) && !manual_stop);
    cover property (step);
endmodule : cdts_checker

bind cdts_core cdts_checker cdts_checker_inst (.mclk(mclk),
    .sys_rst(sys_rst), .arm_start(arm_start), .manual_stop(manual_stop),
    .running(running), .stopped(stopped), .write_addr(write_addr));

/* verif/cdts_pod_model.sv */
// Pod model: samples behind a level strobe
`timescale 1ns/10ps
module cdts_pod_model
    import cdts_pkg::*;
(
    input wire logic           mclk,
    output logic [FRAME_W-1:0] pod_data,
    output logic               pod_qual,
    output logic               pod_strobe
);
    // Quiet lines before the first sample
    initial
    begin
        pod_data   = '0;
        pod_qual   = 1'b0;
        pod_strobe = 1'b0;
    end

    // One sample; data goes stale late in the low phase
    task automatic sample(input logic [FRAME_W-1:0] v, input logic q,
                          input int half);
        @(posedge mclk);
        pod_data   <= v;
        pod_qual   <= q;
        pod_strobe <= 1'b1;
        repeat (half) @(posedge mclk);
        pod_strobe <= 1'b0;
        repeat (half - 1) @(posedge mclk);
        pod_data   <= ~v;
        pod_qual   <= ~q;
    endtask : sample
endmodule : cdts_pod_model

/* verif/tb.sv */
// Self-checking bench for the capture core
`timescale 1ns/10ps
module tb
    import cdts_pkg::*;
;
    logic mclk, sys_rst, pod_qual, pod_strobe, qual_enable;
    logic arm_start, manual_stop, running, stopped, frame_lost;
    logic [FRAME_W-1:0] pod_data, read_data;
    logic [DELAY_W-1:0] stop_delay;
    logic [ACQ_AW-1:0]  read_addr, write_addr;
    cdts_width_t        width_sel;
    cdts_load_t         load_port;
    int                 mismatches, total_checks;

    cdts_core cdts_core_inst (.mclk(mclk), .sys_rst(sys_rst),
        .pod_data(pod_data), .pod_qual(pod_qual), .pod_strobe(pod_strobe),
        .width_sel(width_sel), .qual_enable(qual_enable),
        .stop_delay(stop_delay), .load_port(load_port),
        .arm_start(arm_start), .manual_stop(manual_stop),
        .read_addr(read_addr), .read_data(read_data), .running(running),
        .stopped(stopped), .write_addr(write_addr), .frame_lost(frame_lost));
    cdts_pod_model cdts_pod_model_inst (.mclk(mclk), .pod_data(pod_data),
        .pod_qual(pod_qual), .pod_strobe(pod_strobe));

    // 100 MHz clock
    initial
    begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("wrong value at %0t: %h vs %h", $time, got, exp);
        end
    endtask : chk

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : report_and_stop

    // Bounded wait for a slot count and stop state, sampled mid-cycle
    task automatic wait_for(input logic [ACQ_AW-1:0] t, input logic s);
        int n;
        n = 0;
        @(negedge mclk);
        while ((write_addr !== t || stopped !== s) && n < 99)
        begin
            @(negedge mclk);
            n++;
        end
        chk({stopped, write_addr}, {s, t});
        // Bound used up without a match: already counted, end the run
        if (write_addr !== t || stopped !== s)
            report_and_stop();
    endtask : wait_for

    task automatic pulse(input logic arm);
        @(posedge mclk);
        arm_start   <= arm;
        manual_stop <= !arm;
        @(posedge mclk);
        arm_start   <= 1'b0;
        manual_stop <= 1'b0;
    endtask : pulse

    // Split a frame into samples, lowest lane first
    task automatic send(input cdts_width_t w, input logic [31:0] f,
                        input logic q);
        int b;
        b = 4 << w;
        for (int i = 0; i < 32 / b; i++)
            cdts_pod_model_inst.sample(32'((f >> (b * i)) &
                ((64'h1 << b) - 1)), q, w == CDTS_W32 ? 4 : 2);
    endtask : send

    task automatic read_slot(input logic [ACQ_AW-1:0] a,
                             input logic [31:0] exp);
        @(posedge mclk);
        read_addr <= a;
        repeat (2) @(negedge mclk);
        chk(read_data, exp);
    endtask : read_slot

    // Lookup tables: A (0A1) is word 1, B (0B2) word 2; seq needs A then B
    task automatic load_luts;
        for (int i = 0; i < 4096; i++)
        begin
            @(posedge mclk);
            load_port <= '{1'b0, i[11:0], i == 12'h0A1 ? 4'h1 :
                           i == 12'h0B2 ? 4'h2 : 4'h0, 1'b1};
        end
        for (int i = 0; i < 32; i++)
        begin
            @(posedge mclk);
            load_port <= '{1'b1, i[11:0], i == 1 ? 4'h1 : i == 6 ? 4'h8 :
                           {2'h0, i[3:2]}, 1'b1};
        end
        @(posedge mclk);
        load_port.we <= 1'b0;
    endtask : load_luts

    // Every width packs one frame; samples after a stop are dropped
    task automatic t_pack;
        logic [31:0] f [4];
        f = '{32'h8765_4321, 32'h4433_2211, 32'h5678_1234, 32'hCAFE_0001};
        for (int k = 0; k < 4; k++)
        begin
            @(posedge mclk);
            width_sel <= cdts_width_t'(k);
            pulse(1'b1);
            // Status flags are registered one cycle behind the run state
            repeat (2) @(negedge mclk);
            chk({running, stopped}, 2'h2);
            send(cdts_width_t'(k), f[k], 1'b0);
            wait_for(10'h1, 1'b0);
            pulse(1'b0);
            wait_for(10'h1, 1'b1);
            chk(running, 1'h0);
            send(cdts_width_t'(k), ~f[k], 1'b0);
            repeat (8) @(negedge mclk);
            chk(write_addr, 10'h1);
            read_slot(10'h0, f[k]);
        end
    endtask : t_pack

    // Qualifier ignored in 8-bit mode, gates stores in 32-bit mode
    task automatic t_qual;
        @(posedge mclk);
        qual_enable <= 1'b1;
        width_sel   <= CDTS_W8;
        pulse(1'b1);
        send(CDTS_W8, 32'h0403_0201, 1'b0);
        wait_for(10'h1, 1'b0);
        pulse(1'b0);
        width_sel <= CDTS_W32;
        pulse(1'b1);
        send(CDTS_W32, 32'h0000_0100, 1'b1);
        send(CDTS_W32, 32'h0000_0200, 1'b0);
        send(CDTS_W32, 32'h0000_0300, 1'b1);
        wait_for(10'h2, 1'b0);
        pulse(1'b0);
        qual_enable <= 1'b0;
        read_slot(10'h1, 32'h0000_0300);
    endtask : t_qual

    // B alone does nothing, A then B stops after three more samples
    task automatic t_seq;
        int n;
        n = 0;
        @(posedge mclk);
        stop_delay <= 16'h0003;
        pulse(1'b1);
        send(CDTS_W32, 32'h0000_00B2, 1'b1);
        send(CDTS_W32, 32'h0000_00A1, 1'b1);
        send(CDTS_W32, 32'h0000_0003, 1'b1);
        chk(stopped, 1'h0);
        send(CDTS_W32, 32'h0000_00B2, 1'b1);
        while (stopped !== 1'b1 && n < 8)
        begin
            send(CDTS_W32, 32'h0000_0010, 1'b1);
            n++;
        end
        wait_for(10'h7, 1'b1);
        repeat (8) @(negedge mclk);
        chk({running, write_addr}, 11'h007);
        chk(frame_lost, 1'b0);
    endtask : t_seq

    initial
    begin
        sys_rst      = 1'b1;
        width_sel    = CDTS_W4;
        qual_enable  = 1'b0;
        stop_delay   = '0;
        load_port    = '0;
        arm_start    = 1'b0;
        manual_stop  = 1'b0;
        read_addr    = '0;
        mismatches   = 0;
        total_checks = 0;
        repeat (8) @(posedge mclk);
        sys_rst <= 1'b0;
        @(negedge mclk);
        chk({running, stopped, write_addr}, 32'h0);
        load_luts();
        t_pack();
        t_qual();
        t_seq();
        report_and_stop();
    end

    // Hang guard
    initial
    begin
        repeat (100000) @(posedge mclk);
        mismatches++;
        report_and_stop();
    end
endmodule : tb
